// [design/otg_vbus_power_control.sv]
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps

// Behaviour
// - supply enable is high when drive or drive-external control bit set
// - supply enable is active high; low keeps the external supply off
// - both drive bits clear at power-on reset, supply enable starts low
// - use-indicator clear: reported valid follows internal comparator only
// - use, bypass set, invert clear: reported valid equals indicator pin
// - use, bypass and invert set: reported valid is inverted indicator pin
// - use set, bypass clear: indicator, maybe inverted, ANDed with comparator
// - invert selection lives in interface control bit 5
// - bypass selection lives in interface control bit 6
// - indicator pin feeds reported valid only while otg control bit 7 is set
// - pin pull-down enabled while use-indicator is 0, off while 1
module otg_vbus_power_control (
    input  wire logic                                clk,
    input  wire logic                                resetn,
    input  wire logic                                clk_en,
    input  wire logic [otg_power_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [otg_power_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [otg_power_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic                                bus_power_valid_cmp,
    input  wire logic                                ext_indicator_pin,
    output logic                                     ext_supply_enable,
    output logic                                     ext_pulldown_enable,
    output logic                                     rxcmd_bus_power_valid,
    output logic                                     irq
);

    // synchroniser chains: index 0 comparator, index 1 indicator pin
    localparam int NSYNC = 2;

    logic [NSYNC-1:0]                         raw_in;
    logic [otg_power_pkg::SYNC_STAGES-1:0]    sync_reg  [NSYNC];
    logic [otg_power_pkg::SYNC_STAGES-1:0]    sync_next [NSYNC];
    logic                                     filt_reg  [NSYNC];
    logic                                     filt_next [NSYNC];

    otg_power_pkg::otg_ctrl_type              otg_reg;
    otg_power_pkg::otg_ctrl_type              otg_next;
    otg_power_pkg::if_ctrl_type               ifc_reg;
    otg_power_pkg::if_ctrl_type               ifc_next;
    otg_power_pkg::irq_type                   stat_reg;
    otg_power_pkg::irq_type                   stat_next;
    otg_power_pkg::irq_type                   mask_reg;
    otg_power_pkg::irq_type                   mask_next;

    logic                                     supply_reg;
    logic                                     supply_next;
    logic                                     pulldown_reg;
    logic                                     pulldown_next;
    logic                                     report_reg;
    logic                                     report_next;
    logic                                     irq_reg;
    logic                                     irq_next;
    logic [otg_power_pkg::DATA_W-1:0]         rdata_reg;
    logic [otg_power_pkg::DATA_W-1:0]         rdata_next;

    logic                                     cmp_filt;
    logic                                     ind_filt;
    logic                                     ind_polar;
    otg_power_pkg::irq_type                   events;
    otg_power_pkg::irq_type                   clear_bits;

    assign raw_in   = {ext_indicator_pin, bus_power_valid_cmp};
    assign cmp_filt = filt_reg[0];
    assign ind_filt = filt_reg[1];

    // three-stage chains; a change is taken once stages two and three agree
    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_comb begin
                sync_next[i] = {sync_reg[i][1:0], raw_in[i]};
                filt_next[i] = filt_reg[i];
                if (sync_reg[i][1] == sync_reg[i][2]) begin
                    filt_next[i] = sync_reg[i][2];
                end
            end

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync_reg[i] <= '0;
                    filt_reg[i] <= 1'b0;
                end else if (clk_en) begin
                    sync_reg[i] <= sync_next[i];
                    filt_reg[i] <= filt_next[i];
                end
            end
        end
    endgenerate

    // control registers written by the link
    always_comb begin
        otg_next  = otg_reg;
        ifc_next  = ifc_reg;
        mask_next = mask_reg;
        if (reg_wr) begin
            case (reg_addr)
                otg_power_pkg::OFS_OTG_CTRL: begin
                    otg_next = otg_power_pkg::otg_ctrl_type'(reg_wdata);
                end
                otg_power_pkg::OFS_IF_CTRL: begin
                    ifc_next = otg_power_pkg::if_ctrl_type'(reg_wdata);
                end
                otg_power_pkg::OFS_IRQ_MASK: begin
                    mask_next = otg_power_pkg::irq_type'(reg_wdata);
                end
                default: begin
                    otg_next = otg_reg; // status and unmapped writes ignored
                end
            endcase
        end
    end

    // drive bits come up clear so the external supply is off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            otg_reg  <= otg_power_pkg::otg_ctrl_type'(otg_power_pkg::OTG_CTRL_RESET);
            ifc_reg  <= otg_power_pkg::if_ctrl_type'(otg_power_pkg::IF_CTRL_RESET);
            mask_reg <= otg_power_pkg::irq_type'(otg_power_pkg::IRQ_RESET);
        end else if (clk_en) begin
            otg_reg  <= otg_next;
            ifc_reg  <= ifc_next;
            mask_reg <= mask_next;
        end
    end

    // supply enable, pull-down and the valid source selection
    always_comb begin
        supply_next   = otg_reg.drive_bus_power | otg_reg.drive_bus_power_ext;
        pulldown_next = ~otg_reg.use_ext_indicator;
        ind_polar     = ind_filt ^ ifc_reg.indicator_invert;
        if (!otg_reg.use_ext_indicator) begin
            report_next = cmp_filt;
        end else if (ifc_reg.indicator_bypass_qualify) begin
            report_next = ind_polar;
        end else begin
            // qualified mode is legal but discouraged for the link
            report_next = ind_polar & cmp_filt;
        end
    end

    // sticky events; a set in the clearing cycle wins over the clear
    always_comb begin
        events            = '0;
        events.valid_rise = report_next & ~report_reg;
        events.valid_fall = ~report_next & report_reg;
        events.ind_change = filt_next[1] ^ filt_reg[1];
        clear_bits        = '0;
        if (reg_wr && reg_addr == otg_power_pkg::OFS_IRQ_STATUS) begin
            clear_bits = otg_power_pkg::irq_type'(reg_wdata);
        end
        stat_next         = (stat_reg & ~clear_bits) | events;
        stat_next.spare   = '0;
        irq_next          = |(stat_next & mask_next);
    end

    // read data appear in the cycle after the read strobe only
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                otg_power_pkg::OFS_OTG_CTRL:   rdata_next = otg_reg;
                otg_power_pkg::OFS_IF_CTRL:    rdata_next = ifc_reg;
                otg_power_pkg::OFS_STATUS: begin
                    rdata_next = {4'h0, supply_reg, report_reg, ind_filt, cmp_filt};
                end
                otg_power_pkg::OFS_IRQ_STATUS: rdata_next = stat_reg;
                otg_power_pkg::OFS_IRQ_MASK:   rdata_next = mask_reg;
                default:                       rdata_next = '0;
            endcase
        end
    end

    // every output leaves from a flip-flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            supply_reg   <= 1'b0;
            pulldown_reg <= 1'b1;
            report_reg   <= 1'b0;
            stat_reg     <= otg_power_pkg::irq_type'(otg_power_pkg::IRQ_RESET);
            irq_reg      <= 1'b0;
            rdata_reg    <= '0;
        end else if (clk_en) begin
            supply_reg   <= supply_next;
            pulldown_reg <= pulldown_next;
            report_reg   <= report_next;
            stat_reg     <= stat_next;
            irq_reg      <= irq_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign ext_supply_enable     = supply_reg;
    assign ext_pulldown_enable   = pulldown_reg;
    assign rxcmd_bus_power_valid = report_reg;
    assign irq                   = irq_reg;
    assign reg_rdata             = rdata_reg;

    // checks, all in the clk domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_supply_or;
        clk_en |=> ext_supply_enable ==
            ($past(otg_reg.drive_bus_power) || $past(otg_reg.drive_bus_power_ext));
    endproperty
    a_supply_or: assert property (p_supply_or) else $error("supply enable not OR of drive bits");

    property p_supply_off;
        clk_en && !otg_reg.drive_bus_power && !otg_reg.drive_bus_power_ext
            ##1 clk_en && !otg_reg.drive_bus_power && !otg_reg.drive_bus_power_ext
            |=> !ext_supply_enable [*1];
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("supply enabled with drive bits clear");

    property p_reset_state;
        $rose(resetn) |-> !ext_supply_enable && !otg_reg.drive_bus_power && !otg_reg.drive_bus_power_ext;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("drive bits not clear after reset");

    property p_internal_src;
        clk_en && !otg_reg.use_ext_indicator |=> rxcmd_bus_power_valid == $past(cmp_filt);
    endproperty
    a_internal_src: assert property (p_internal_src) else $error("default source not comparator");

    property p_ext_high;
        clk_en && otg_reg.use_ext_indicator && ifc_reg.indicator_bypass_qualify && !ifc_reg.indicator_invert
            |=> rxcmd_bus_power_valid == $past(ind_filt);
    endproperty
    a_ext_high: assert property (p_ext_high) else $error("active high indicator not passed");

    property p_ext_low;
        clk_en && otg_reg.use_ext_indicator && ifc_reg.indicator_bypass_qualify && ifc_reg.indicator_invert
            |=> rxcmd_bus_power_valid == !$past(ind_filt);
    endproperty
    a_ext_low: assert property (p_ext_low) else $error("active low indicator not inverted");

    property p_qualified;
        clk_en && otg_reg.use_ext_indicator && !ifc_reg.indicator_bypass_qualify
            |=> rxcmd_bus_power_valid ==
                (($past(ind_filt) ^ $past(ifc_reg.indicator_invert)) && $past(cmp_filt));
    endproperty
    a_qualified: assert property (p_qualified) else $error("qualified indicator wrong");

    property p_pulldown;
        clk_en |=> ext_pulldown_enable == !$past(otg_reg.use_ext_indicator);
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down not tied to use bit");

    property p_sync_settle;
        (clk_en && ext_indicator_pin) [*5] |-> ind_filt;
    endproperty
    a_sync_settle: assert property (p_sync_settle) else $error("indicator not settled in time");

    property p_sync_latency;
        clk_en && $rose(ind_filt) |-> $past(ext_indicator_pin, 3);
    endproperty
    a_sync_latency: assert property (p_sync_latency) else $error("indicator taken too early");

    property p_irq_level;
        irq == |(stat_reg & mask_reg);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq does not follow masked status");

    // reset leaves the pin pulled down and the report and irq idle
    property p_pulldown_reset;
        $rose(resetn) |-> ext_pulldown_enable && !rxcmd_bus_power_valid && !irq;
    endproperty
    a_pulldown_reset: assert property (p_pulldown_reset) else $error("outputs not idle after reset");

    // a falling pin must have been low three samples back
    property p_ind_fall;
        clk_en && $fell(ind_filt) |-> !$past(ext_indicator_pin, 3);
    endproperty
    a_ind_fall: assert property (p_ind_fall) else $error("indicator fall taken too early");

    // a low enable freezes the supply, report, irq and read data flops
    property p_freeze;
        !clk_en |=> $stable(ext_supply_enable) && $stable(rxcmd_bus_power_valid)
            && $stable(irq) && $stable(reg_rdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while clock enable low");

    // read data stand only after a read strobe
    property p_rdata_idle;
        clk_en && !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read strobe");

    property p_rdata_otg;
        clk_en && reg_rd && reg_addr == otg_power_pkg::OFS_OTG_CTRL |=> reg_rdata == $past(otg_reg);
    endproperty
    a_rdata_otg: assert property (p_rdata_otg) else $error("otg control read back wrong");

    // control writes land in the next cycle
    property p_otg_write;
        clk_en && reg_wr && reg_addr == otg_power_pkg::OFS_OTG_CTRL |=> otg_reg == $past(reg_wdata);
    endproperty
    a_otg_write: assert property (p_otg_write) else $error("otg control write lost");

    property p_ifc_write;
        clk_en && reg_wr && reg_addr == otg_power_pkg::OFS_IF_CTRL |=> ifc_reg == $past(reg_wdata);
    endproperty
    a_ifc_write: assert property (p_ifc_write) else $error("interface control write lost");

    property p_mask_write;
        clk_en && reg_wr && reg_addr == otg_power_pkg::OFS_IRQ_MASK |=> mask_reg == $past(reg_wdata);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    // the status offset is read only; writes change no control state
    property p_status_ro;
        clk_en && reg_wr && reg_addr == otg_power_pkg::OFS_STATUS
            |=> otg_reg == $past(otg_reg) && ifc_reg == $past(ifc_reg) && mask_reg == $past(mask_reg);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed a register");

    // an event in the clearing cycle must survive the clear
    property p_set_wins;
        clk_en && events.valid_rise |=> stat_reg.valid_rise;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

    property p_clear;
        clk_en && reg_wr && reg_addr == otg_power_pkg::OFS_IRQ_STATUS && reg_wdata[0] && !events.valid_rise
            |=> !stat_reg.valid_rise;
    endproperty
    a_clear: assert property (p_clear) else $error("status bit not cleared by one");

    // pull-down goes off while the use bit is set
    property p_pulldown_off;
        clk_en && otg_reg.use_ext_indicator |=> !ext_pulldown_enable;
    endproperty
    a_pulldown_off: assert property (p_pulldown_off) else $error("pull-down left on with pin in use");

    c_supply_on: cover property (clk_en && $rose(ext_supply_enable));
    c_ext_low:   cover property (otg_reg.use_ext_indicator && ifc_reg.indicator_invert && $fell(rxcmd_bus_power_valid));
    c_irq:       cover property ($rose(irq));
    c_qual:      cover property (otg_reg.use_ext_indicator && !ifc_reg.indicator_bypass_qualify && rxcmd_bus_power_valid);

endmodule

// [design/otg_power_pkg.sv]
package otg_power_pkg;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] OFS_OTG_CTRL   = 4'h0;
    localparam logic [3:0] OFS_IF_CTRL    = 4'h1;
    localparam logic [3:0] OFS_STATUS     = 4'h2;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
    localparam logic [3:0] OFS_IRQ_MASK   = 4'h4;

    // field positions
    localparam int OTG_DRIVE_BIT     = 5;
    localparam int OTG_DRIVE_EXT_BIT = 6;
    localparam int OTG_USE_EXT_BIT   = 7;
    localparam int IF_INVERT_BIT     = 5;
    localparam int IF_BYPASS_BIT     = 6;

    // values after reset
    localparam logic [7:0] OTG_CTRL_RESET = 8'h00;
    localparam logic [7:0] IF_CTRL_RESET  = 8'h00;
    localparam logic [7:0] IRQ_RESET      = 8'h00;

    // stages of each pin synchroniser
    localparam int SYNC_STAGES = 3;

    // otg control: bit 7 use indicator, 6 drive ext, 5 drive
    typedef struct packed {
        logic       use_ext_indicator;
        logic       drive_bus_power_ext;
        logic       drive_bus_power;
        logic [4:0] spare;
    } otg_ctrl_type;

    // interface control: bit 6 bypass, bit 5 invert
    typedef struct packed {
        logic       spare_hi;
        logic       indicator_bypass_qualify;
        logic       indicator_invert;
        logic [4:0] spare;
    } if_ctrl_type;

    // sticky event bits, same layout in the mask
    typedef struct packed {
        logic [4:0] spare;
        logic       ind_change;
        logic       valid_fall;
        logic       valid_rise;
    } irq_type;

endpackage

// [bench/bus_switch_model.sv]
`timescale 1ns/100ps

// external supply switch plus indicator driver on the far side
module bus_switch_model (
    input  wire logic clk,
    input  wire logic supply_enable,
    input  wire logic pulldown_enable,
    input  wire logic drive_pin,
    input  wire logic pin_level,
    output logic      pin,
    output logic      supply_on
);
    logic toggle_reg;

    // switch conducts only on a high enable, low keeps supply off
    assign supply_on = supply_enable;

    // peripheral start is keyed to session valid on the link, not this report
    // released pin floats: a toggling level so nothing passes by luck
    always @(posedge clk) begin
        toggle_reg <= ~toggle_reg;
    end

    // pull-down holds the pin low once the driver lets go
    always_comb begin
        if (drive_pin) begin
            pin = pin_level;
        end else if (pulldown_enable) begin
            pin = 1'b0;
        end else begin
            pin = toggle_reg;
        end
    end

    initial toggle_reg = 1'b0;
endmodule

// [bench/otg_vbus_power_control_tb.sv]
`timescale 1ns/100ps

module otg_vbus_power_control_tb;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       cmp = 1'b0;
    logic       pin;
    logic       drive_pin = 1'b0;
    logic       pin_level = 1'b0;
    logic       supply_en;
    logic       pd_en;
    logic       rx_valid;
    logic       irq;
    logic       supply_on;
    int         bad_count = 0;
    int         total_checks = 0;
    // row: otg ctrl, if ctrl, comparator, pin, supply, pull-down, rx valid
    // qualified rows only prove the selection; a real link avoids that mode
    logic [20:0] rows [12] = '{
        {8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1}, {8'h20, 8'h60, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0},
        {8'h40, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}, {8'h60, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
        {8'h80, 8'h40, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1}, {8'h80, 8'h40, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        {8'h80, 8'h60, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1}, {8'h80, 8'h60, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
        {8'h80, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1}, {8'h80, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0},
        {8'h80, 8'h20, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1}, {8'hA0, 8'h20, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0}};

    always #12.5 clk = ~clk;

    otg_vbus_power_control u_dut (
        .clk                   (clk),
        .resetn                (resetn),
        .clk_en                (clk_en),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .bus_power_valid_cmp   (cmp),
        .ext_indicator_pin     (pin),
        .ext_supply_enable     (supply_en),
        .ext_pulldown_enable   (pd_en),
        .rxcmd_bus_power_valid (rx_valid),
        .irq                   (irq)
    );

    bus_switch_model u_far (
        .clk             (clk),
        .supply_enable   (supply_en),
        .pulldown_enable (pd_en),
        .drive_pin       (drive_pin),
        .pin_level       (pin_level),
        .pin             (pin),
        .supply_on       (supply_on)
    );

    // one compare, counted, reported at once on a mismatch
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("read data", reg_rdata, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        settle(1);
        check("supply after reset", supply_en, 8'h00);
        check("pull-down after reset", pd_en, 8'h01);
        rd(otg_power_pkg::OFS_OTG_CTRL, otg_power_pkg::OTG_CTRL_RESET);
        rd(otg_power_pkg::OFS_IF_CTRL, otg_power_pkg::IF_CTRL_RESET);
        rd(otg_power_pkg::OFS_IRQ_MASK, otg_power_pkg::IRQ_RESET);
        $display("test reset done");
        // table of selection modes; pin is driven by the far side throughout
        drive_pin <= 1'b1;
        foreach (rows[i]) begin
            wr(otg_power_pkg::OFS_OTG_CTRL, rows[i][20:13]);
            wr(otg_power_pkg::OFS_IF_CTRL, rows[i][12:5]);
            cmp <= rows[i][4];
            pin_level <= rows[i][3];
            settle(8);
            check("supply enable", supply_en, {7'h00, rows[i][2]});
            check("switch state", supply_on, {7'h00, rows[i][2]});
            check("pull-down", pd_en, {7'h00, rows[i][1]});
            check("rx valid", rx_valid, {7'h00, rows[i][0]});
            rd(otg_power_pkg::OFS_OTG_CTRL, rows[i][20:13]);
        end
        // status after last row: supply on, report low, pin high, comparator high
        rd(otg_power_pkg::OFS_STATUS, 8'h0B);
        $display("test modes done");
        // pin pass-through latency: two flops at least before it shows
        wr(otg_power_pkg::OFS_IF_CTRL, 8'h40);
        wr(otg_power_pkg::OFS_OTG_CTRL, 8'h80);
        pin_level <= 1'b0;
        settle(8);
        @(posedge clk);
        pin_level <= 1'b1;
        settle(2);
        check("rx before sync", rx_valid, 8'h00);
        settle(6);
        check("rx after sync", rx_valid, 8'h01);
        $display("test sync done");
        // released pin with indicator unused reads low through the pull-down
        wr(otg_power_pkg::OFS_OTG_CTRL, 8'h00);
        drive_pin <= 1'b0;
        settle(4);
        check("released pin", pin, 8'h00);
        // interrupt: raise, clear, mask
        cmp <= 1'b0;
        wr(otg_power_pkg::OFS_IRQ_MASK, 8'h01);
        settle(8);
        wr(otg_power_pkg::OFS_IRQ_STATUS, 8'hFF);
        settle(2);
        check("irq idle", irq, 8'h00);
        cmp <= 1'b1;
        settle(8);
        check("irq on rise", irq, 8'h01);
        rd(otg_power_pkg::OFS_IRQ_STATUS, 8'h01);
        wr(otg_power_pkg::OFS_IRQ_STATUS, 8'h01);
        settle(2);
        check("irq cleared", irq, 8'h00);
        cmp <= 1'b0;
        settle(8);
        check("irq masked", irq, 8'h00);
        rd(otg_power_pkg::OFS_IRQ_STATUS, 8'h02);
        $display("test irq done");
        // unmapped read, read-only status write, then a control read back
        rd(4'hF, 8'h00);
        wr(otg_power_pkg::OFS_STATUS, 8'hFF);
        rd(otg_power_pkg::OFS_OTG_CTRL, 8'h00);
        // clock enable low: a write is not taken and the supply stays off
        clk_en <= 1'b0;
        wr(otg_power_pkg::OFS_OTG_CTRL, 8'h20);
        settle(2);
        check("frozen supply", supply_en, 8'h00);
        clk_en <= 1'b1;
        rd(otg_power_pkg::OFS_OTG_CTRL, 8'h00);
        // reset in mid-run drops the supply at once
        wr(otg_power_pkg::OFS_OTG_CTRL, 8'h60);
        settle(4);
        check("supply on", supply_en, 8'h01);
        resetn <= 1'b0;
        #1 check("supply in reset", supply_en, 8'h00);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(otg_power_pkg::OFS_OTG_CTRL, 8'h00);
        $display("test awkward done");
        close_out();
    end
endmodule
